/* File: spf_pkg.sv */
// Package for the six-output PWM and fault protection block.
package spf_pkg;
  localparam int CNT_W = 10;
  // Register offsets.
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_D = 4'h1;
  localparam logic [3:0] ADDR_OVR = 4'h2;
  localparam logic [3:0] ADDR_CMP_A = 4'h3;
  localparam logic [3:0] ADDR_TOP = 4'h4;
  localparam logic [3:0] ADDR_PORT = 4'h5;
  localparam logic [3:0] ADDR_STAT = 4'h6;
  localparam logic [3:0] ADDR_COUNT = 4'h7;
  localparam logic [3:0] ADDR_PRESC = 4'h8;
  // Control A fields.
  localparam int CA_PWM_EN = 0;
  localparam int CA_WM0 = 1;
  localparam int CA_WM1 = 2;
  localparam int CA_MODE_A = 3;
  localparam int CA_MODE_B = 5;
  localparam int CA_MODE_D = 7;
  // Control D fields.
  localparam int CD_FEN = 0;
  localparam int CD_FIE = 1;
  localparam int CD_FSRC = 2;
  localparam int CD_FNC = 3;
  localparam int CD_FEDGE = 4;
  // Status fields.
  localparam int ST_FFLAG = 0;
  localparam int ST_TOV = 1;
  // Reset values.
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [9:0] RST_TOP = 10'h3FF;
  localparam logic [15:0] RST_PRESC = 16'h0000;
  localparam int FILT_SAMPLES = 4;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } spf_bus_t;
endpackage

/* File: spf_fault_in.sv */
// Fault input sampler, optional four-sample noise filter and edge detector.
`timescale 1ns/1ps
module spf_fault_in #(
  parameter int SAMPLES = spf_pkg::FILT_SAMPLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Input and settings
  input wire logic din,
  input wire logic filterEn,
  input wire logic risingEdge,
  // Event out
  output logic edgeHit
);
  import spf_pkg::*;
  logic syncA_r, syncB_r, prev_r, filt_r, filt_nxt;
  logic [SAMPLES-2:0] hist_r;
  logic stage;
  // The newest sample joins the window unregistered, so the filtered path
  // costs exactly four cycles more than the direct one.
  wire [SAMPLES-1:0] window = {hist_r, syncB_r};
  wire allHigh = &window;
  wire allLow = ~|window;
  // The filter runs on the system clock; the prescaler never reaches it.
  always_comb begin
    filt_nxt = filt_r;
    if (allHigh) filt_nxt = 1'b1;
    else if (allLow) filt_nxt = 1'b0;
  end
  assign stage = filterEn ? filt_r : syncB_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      hist_r <= '0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      syncA_r <= din;
      syncB_r <= syncA_r;
      hist_r <= window[SAMPLES-2:0];
      filt_r <= filt_nxt;
      prev_r <= stage;
    end
  end
  assign edgeHit = risingEdge ? (stage & ~prev_r) : (~stage & prev_r);
endmodule

/* File: spf_top.sv */
// Six-output PWM timer with fault protection, top level.
`timescale 1ns/1ps
//
// Operation
// - Six-output mode when PWM enable and mode bit 1 set, bit 0 ignored.
// - Channel A waveform feeds all six output pins.
// - Cleared override bit puts port value on that pin at once.
// - Mode bit 0 low: count zero to top, then restart from zero.
// - Single slope: waveform flips on compare match, returns at wrap.
// - Single slope: overflow flag set when counter reaches top.
// - Mode bit 0 high: count up to top, then down to zero.
// - Dual slope: one level on up match, opposite on down match.
// - Dual slope: overflow flag set when counter reaches zero.
// - Single slope: counter clears on enable cycle after reaching top.
// - Nonzero pair mode drives both pins with waveform and override bits.
// - Enabled fault unit triggers on matching edge of chosen source.
// - Fault clears output modes, port bits then drive the pins.
// - Fault enable clears in the same cycle as the output modes.
// - Fault with interrupt enable raises the fault interrupt request.
// - Fault source is the interrupt pin, or comparator if bit set.
// - Source change may cause spurious trigger; software clears flag.
// - Fault inputs pass a two-stage sampler and edge detector.
// - Filter output changes only after four agreeing samples.
// - Filter enable inserts the filter and adds four cycles delay.
// - Filter samples on the system clock, not the prescaled one.
module spf_top
  import spf_pkg::*;
#(
  parameter int CW = spf_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire spf_pkg::spf_bus_t bus,
  output logic [15:0] rdata,
  // Fault sources
  input wire logic extIntPin,
  input wire logic comparatorOut,
  // Pins and events
  output logic [5:0] pwmPin,
  output logic [5:0] pwmPinOe,
  output logic faultIrq,
  output logic overflowIrq
);
  import spf_pkg::*;

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [15:0] ctrlA_r, ctrlD_r, presc_r;
  logic [5:0] override_r, port_r;
  logic [CW-1:0] cmpA_r, top_r, count_r, count_nxt;
  logic [15:0] div_r;
  logic down_r, down_nxt, wave_r, wave_nxt;
  logic fflag_r, tov_r;
  logic [15:0] rdata_nxt;

  wire wrCtrlA = bus.wr && (bus.addr == ADDR_CTRL_A);
  wire wrCtrlD = bus.wr && (bus.addr == ADDR_CTRL_D);
  wire wrOvr = bus.wr && (bus.addr == ADDR_OVR);
  wire wrCmpA = bus.wr && (bus.addr == ADDR_CMP_A);
  wire wrTop = bus.wr && (bus.addr == ADDR_TOP);
  wire wrPort = bus.wr && (bus.addr == ADDR_PORT);
  wire wrStat = bus.wr && (bus.addr == ADDR_STAT);
  wire wrCount = bus.wr && (bus.addr == ADDR_COUNT);
  wire wrPresc = bus.wr && (bus.addr == ADDR_PRESC);

  // --------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------
  wire sixMode = ctrlA_r[CA_PWM_EN] & ctrlA_r[CA_WM1];
  wire dualSlope = ctrlA_r[CA_WM0];
  wire [1:0] modeA = ctrlA_r[CA_MODE_A +: 2];
  wire [1:0] modeB = ctrlA_r[CA_MODE_B +: 2];
  wire [1:0] modeD = ctrlA_r[CA_MODE_D +: 2];
  // Inverted polarity is taken from channel A mode three.
  wire invert = (modeA == 2'b11);

  // --------------------------------------------------------------
  // Timer clock enable
  // --------------------------------------------------------------
  wire tick = (div_r == presc_r);

  // --------------------------------------------------------------
  // Counter and waveform
  // --------------------------------------------------------------
  wire atTop = (count_r == top_r);
  wire atZero = (count_r == '0);
  wire match = (count_r == cmpA_r);
  always_comb begin
    count_nxt = count_r;
    down_nxt = down_r;
    wave_nxt = wave_r;
    if (!dualSlope) begin
      down_nxt = 1'b0;
      if (atTop) begin
        count_nxt = '0;
        wave_nxt = ~invert;
      end else begin
        count_nxt = count_r + 1'b1;
      end
      if (match && !atTop) wave_nxt = invert;
    end else begin
      if (!down_r) begin
        if (atTop) begin
          down_nxt = 1'b1;
          count_nxt = count_r - 1'b1;
        end else begin
          count_nxt = count_r + 1'b1;
        end
        if (match) wave_nxt = invert;
      end else begin
        if (atZero) begin
          down_nxt = 1'b0;
          count_nxt = count_r + 1'b1;
        end else begin
          count_nxt = count_r - 1'b1;
        end
        if (match) wave_nxt = ~invert;
      end
    end
  end

  wire tovHit = tick && sixMode && (dualSlope ? atZero && down_r : atTop);

  // --------------------------------------------------------------
  // Fault unit
  // --------------------------------------------------------------
  logic faultEdge;
  wire faultSrc = ctrlD_r[CD_FSRC] ? comparatorOut : extIntPin;
  spf_fault_in #(.SAMPLES(FILT_SAMPLES)) uFault (
    .clk(clk),
    .rstn(rstn),
    .din(faultSrc),
    .filterEn(ctrlD_r[CD_FNC]),
    .risingEdge(ctrlD_r[CD_FEDGE]),
    .edgeHit(faultEdge)
  );
  wire faultTrig = ctrlD_r[CD_FEN] & faultEdge;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlA_r <= RST_CTRL;
      ctrlD_r <= RST_CTRL;
    end else begin
      if (faultTrig) begin
        // Hardware wins over a same-cycle software write.
        ctrlA_r <= wrCtrlA ? (bus.wdata & 16'hFE07) : (ctrlA_r & 16'hFE07);
        ctrlD_r <= (wrCtrlD ? bus.wdata : ctrlD_r) & 16'hFFFE;
      end else begin
        if (wrCtrlA) ctrlA_r <= bus.wdata;
        if (wrCtrlD) ctrlD_r <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fflag_r <= 1'b0;
      tov_r <= 1'b0;
    end else begin
      // Set beats write-one-to-clear.
      if (faultTrig) fflag_r <= 1'b1;
      else if (wrStat && bus.wdata[ST_FFLAG]) fflag_r <= 1'b0;
      if (tovHit) tov_r <= 1'b1;
      else if (wrStat && bus.wdata[ST_TOV]) tov_r <= 1'b0;
    end
  end
  assign faultIrq = fflag_r & ctrlD_r[CD_FIE];
  assign overflowIrq = tov_r;

  // --------------------------------------------------------------
  // Other registers and the timer
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      override_r <= 6'h00;
      port_r <= 6'h00;
      cmpA_r <= '0;
      top_r <= RST_TOP;
      presc_r <= RST_PRESC;
    end else begin
      if (wrOvr) override_r <= bus.wdata[5:0];
      if (wrPort) port_r <= bus.wdata[5:0];
      if (wrCmpA) cmpA_r <= bus.wdata[CW-1:0];
      if (wrTop) top_r <= bus.wdata[CW-1:0];
      if (wrPresc) presc_r <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 16'h0000;
      count_r <= '0;
      down_r <= 1'b0;
      wave_r <= 1'b0;
    end else begin
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
      if (wrCount) begin
        count_r <= bus.wdata[CW-1:0];
      end else if (tick && sixMode) begin
        count_r <= count_nxt;
        down_r <= down_nxt;
        wave_r <= wave_nxt;
      end
    end
  end

  // --------------------------------------------------------------
  // Pin routing
  // --------------------------------------------------------------
  wire [2:0] pairOn = {modeD != 2'b00, modeB != 2'b00, modeA != 2'b00};
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gPin
      wire conn = sixMode & pairOn[g/2];
      assign pwmPin[g] = (conn && override_r[g]) ? wave_r : port_r[g];
      assign pwmPinOe[g] = 1'b1;
    end
  endgenerate

  // --------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (bus.addr)
      ADDR_CTRL_A: rdata_nxt = ctrlA_r;
      ADDR_CTRL_D: rdata_nxt = ctrlD_r;
      ADDR_OVR: rdata_nxt = {10'h000, override_r};
      ADDR_CMP_A: rdata_nxt = 16'(cmpA_r);
      ADDR_TOP: rdata_nxt = 16'(top_r);
      ADDR_PORT: rdata_nxt = {10'h000, port_r};
      ADDR_STAT: rdata_nxt = {14'h0000, tov_r, fflag_r};
      ADDR_COUNT: rdata_nxt = 16'(count_r);
      ADDR_PRESC: rdata_nxt = presc_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata <= 16'h0000;
    else if (bus.rd) rdata <= rdata_nxt;
    else rdata <= 16'h0000;
  end
endmodule

/* File: spf_top_monitor.sv */
// Port-level checker for the six-output PWM and fault block.
`timescale 1ns/1ps
module spf_top_monitor
  import spf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire spf_pkg::spf_bus_t bus,
  input wire logic [15:0] rdata,
  // Pins and events
  input wire logic extIntPin,
  input wire logic comparatorOut,
  input wire logic [5:0] pwmPin,
  input wire logic [5:0] pwmPinOe,
  input wire logic faultIrq,
  input wire logic overflowIrq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Cycles since a fault source last moved; the filtered path needs
  // seven, so sixteen leaves margin without hiding a stray flag.
  logic [4:0] quiet_r;
  logic [1:0] src_r;
  wire logic moved = {extIntPin, comparatorOut} != src_r;
  wire logic stW1c = bus.wr && bus.addr == ADDR_STAT;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quiet_r <= 5'h1F;
      src_r <= 2'h0;
    end else begin
      src_r <= {extIntPin, comparatorOut};
      quiet_r <= moved ? 5'h00 : quiet_r + {4'h0, quiet_r != 5'h1F};
    end
  end
  a_oe_always_on: assert property (pwmPinOe == 6'h3F)
    else $error("pin drive enable dropped");
  a_rdata_idle_zero: assert property (!$past(bus.rd) |->
    rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_ovf_read_back: assert property (bus.rd && bus.addr == ADDR_STAT |=>
    rdata[ST_TOV] == $past(overflowIrq))
    else $error("overflow bit read wrong");
  a_ovf_flag_sticky: assert property ($fell(overflowIrq) |->
    $past(stW1c && bus.wdata[ST_TOV]))
    else $error("overflow flag fell by itself");
  a_ovf_flag_clear: assert property (stW1c && bus.wdata[ST_TOV] |=>
    !overflowIrq)
    else $error("overflow flag not cleared");
  a_fault_irq_sticky: assert property ($fell(faultIrq) |->
    $past(bus.wr))
    else $error("fault request fell by itself");
  a_fault_irq_cause: assert property ($rose(faultIrq) |->
    quiet_r < 5'h10 || $past(bus.wr))
    else $error("fault request with no source edge");
  a_fault_flag_clear: assert property (stW1c && bus.wdata[ST_FFLAG] &&
    quiet_r > 5'h10 |=> !faultIrq)
    else $error("fault flag not cleared");
endmodule

bind spf_top spf_top_monitor u_mon (
  .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
  .extIntPin(extIntPin), .comparatorOut(comparatorOut),
  .pwmPin(pwmPin), .pwmPinOe(pwmPinOe),
  .faultIrq(faultIrq), .overflowIrq(overflowIrq)
);

/* File: spf_fault_src.sv */
// Fault source model: raises one fault line for a set number of cycles.
`timescale 1ns/1ps
module spf_fault_src (
  // Clock
  input wire logic clk,
  // Request
  input wire logic go,
  input wire logic useCmp,
  input wire logic [3:0] len,
  // Fault lines
  output logic extIntPin,
  output logic comparatorOut
);
  logic [3:0] left_r = 4'h0;
  always @(posedge clk) begin
    if (go)
      left_r <= len;
    else if (left_r != 4'h0)
      left_r <= left_r - 4'h1;
  end
  // Both lines are push-pull, so the idle level is a firm low.
  assign extIntPin = !useCmp && left_r != 4'h0;
  assign comparatorOut = useCmp && left_r != 4'h0;
endmodule

/* File: tb_six_output_pwm_fault_protect.sv */
// Self-checking testbench for the six-output PWM and fault block.
`timescale 1ns/1ps
module tb_six_output_pwm_fault_protect;
  import spf_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  spf_bus_t bus = '0;
  logic go = 1'b0;
  logic useCmp = 1'b0;
  logic [3:0] len = 4'h1;
  logic [15:0] rdata, d, p, o;
  logic [5:0] pwmPin, pwmPinOe;
  logic faultIrq, overflowIrq, extIntPin, comparatorOut, dn;
  logic [9:0] v, w, e;
  int mismatches = 0, check_count = 0, cyc = 0, l0, l, hi;
  always #4 clk = !clk;
  spf_top u_dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .extIntPin(extIntPin), .comparatorOut(comparatorOut),
    .pwmPin(pwmPin), .pwmPinOe(pwmPinOe), .faultIrq(faultIrq),
    .overflowIrq(overflowIrq));
  spf_fault_src u_src (.clk(clk), .go(go), .useCmp(useCmp), .len(len),
    .extIntPin(extIntPin), .comparatorOut(comparatorOut));
  task chk(input string n, input logic [15:0] ex, input logic [15:0] g);
    check_count++;
    if (g !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, ex, g);
    end
  endtask
  // High samples in 56 cycles with top 7 and no prescale.
  function automatic int duty(input int c, input bit du, input bit inv);
    int h;
    h = du ? 8 * c : 7 * (c + 1);
    return inv ? 56 - h : h;
  endfunction
  task wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= x;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] x);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 x = rdata;
  endtask
  // Latency in cycles from the request to the fault interrupt request; 99 for none.
  task fault(input logic cmp, input logic [3:0] n, output int lt);
    @(posedge clk);
    useCmp <= cmp;
    len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    lt = 99;
    for (int i = 1; i < 30; i++) begin
      @(posedge clk);
      #1 if (lt == 99 && faultIrq === 1'b1) lt = i;
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    p = $urandom(48750);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_TOP, d); chk("top", 16'h03FF, d);
    rd(ADDR_CTRL_A, d); chk("ctrlA", RST_CTRL, d);
    wr(4'hF, 16'hFFFF); rd(4'hF, d); chk("hole", 16'h0000, d);
    p = $urandom & 16'h003F;
    o = $urandom & 16'h003F;
    wr(ADDR_PORT, p); wr(ADDR_TOP, 16'h0007); wr(ADDR_OVR, o);
    wr(ADDR_CTRL_A, 16'h0155);
    repeat (20) @(posedge clk) #1 chk("ovr", p & ~o, pwmPin & ~o);
    wr(ADDR_OVR, 16'h003F); wr(ADDR_CTRL_A, 16'h0005);
    @(posedge clk) #1 chk("mode0", p, pwmPin);
    wr(ADDR_CTRL_A, 16'h0115);
    @(posedge clk) #1 chk("pairB", p[3:2], pwmPin[3:2]);
    $display("test port done");
    // Settling keeps stale edges out of the window; 56 samples span
    // whole single and dual periods at top 7.
    for (int c = 2; c < 7; c += 2) begin
      wr(ADDR_CMP_A, c);
      wr(ADDR_CTRL_A, c == 4 ? 16'h015D : c == 6 ? 16'h0157 : 16'h0155);
      repeat (16) @(posedge clk);
      hi = 0;
      repeat (56) @(posedge clk) #1 begin
        chk("same", {10'h000, {6{pwmPin[0]}}}, pwmPin);
        hi += pwmPin[0];
      end
      chk("duty", duty(c, c == 6, c == 4), hi);
    end
    $display("test wave done");
    wr(ADDR_PRESC, 16'h0001);
    wr(ADDR_CTRL_A, 16'h0000);
    wr(ADDR_STAT, 16'h0003);
    for (int du = 0; du < 2; du++) begin
      wr(ADDR_CTRL_A, 16'h0155 | (du << 1));
      rd(ADDR_COUNT, d); w = d[9:0];
      rd(ADDR_COUNT, d); v = w; w = d[9:0]; dn = w < v;
      repeat (24) begin
        v = w;
        rd(ADDR_COUNT, d); w = d[9:0];
        if (du == 0) e = v == 10'h007 ? 10'h000 : v + 10'h001;
        else if (dn) e = v == 10'h000 ? 10'h001 : v - 10'h001;
        else e = v == 10'h007 ? 10'h006 : v + 10'h001;
        dn = dn ? v != 10'h000 : v == 10'h007;
        chk("count", e, w);
      end
      rd(ADDR_STAT, d); chk("tov", 1'b1, d[ST_TOV]);
      wr(ADDR_CTRL_A, 16'h0000); wr(ADDR_STAT, 16'h0003);
    end
    $display("test count done");
    // The slow tick keeps the overflow flag from racing its clears.
    wr(ADDR_PRESC, 16'hFFFF); wr(ADDR_CTRL_A, 16'h0155);
    wr(ADDR_CTRL_D, 16'h0013); wr(ADDR_STAT, 16'h0001);
    fault(0, 4'h3, l0); chk("lat", 3, l0);
    chk("fpins", p, pwmPin);
    rd(ADDR_CTRL_A, d); chk("cleared", 16'h0005, d);
    rd(ADDR_CTRL_D, d); chk("fen", 16'h0012, d);
    rd(ADDR_STAT, d); chk("flag", 1'b1, d[ST_FFLAG]);
    wr(ADDR_CTRL_A, 16'h0155); wr(ADDR_CTRL_D, 16'h001B);
    wr(ADDR_STAT, 16'h0001);
    fault(0, 4'h3, l); chk("glitch", 99, l);
    fault(0, 4'h8, l); chk("filt", l0 + 4, l);
    wr(ADDR_CTRL_A, 16'h0155); wr(ADDR_CTRL_D, 16'h0007);
    wr(ADDR_STAT, 16'h0001);
    fault(0, 4'h5, l); chk("srcsel", 99, l);
    fault(1, 4'h5, l); chk("fall", l0 + 5, l);
    wr(ADDR_CTRL_A, 16'h0155); wr(ADDR_CTRL_D, 16'h0011);
    wr(ADDR_STAT, 16'h0001);
    fault(0, 4'h2, l); chk("noirq", 99, l);
    rd(ADDR_STAT, d); chk("flag2", 1'b1, d[ST_FFLAG]);
    wr(ADDR_STAT, 16'h0001);
    rd(ADDR_STAT, d); chk("w1c", 1'b0, d[ST_FFLAG]);
    $display("test fault done");
    conclude();
  end
endmodule
